/* sdram_write_burst_path.sv */
`timescale 1ns/1ps
`default_nettype none

module sdram_write_burst_path (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ck,
  input wire sdram_wr_pkg::link_cmd_t cmd,
  input wire logic on_die_termination,
  input wire logic dqs,
  input wire logic [7:0] dq,
  input wire logic write_data_mask_n,
  output sdram_wr_pkg::write_beat_t beat,
  output logic beat_valid,
  output logic recovery_ref,
  output logic on_die_termination_active,
  output logic termination_strobe_true_active
);
  import sdram_wr_pkg::*;

  function automatic logic burst_is_chop(input logic [1:0] mode, input logic chop_bit);
    burst_is_chop = (mode == burst_fixed_chop) || ((mode == burst_per_command) && !chop_bit);
  endfunction

  // input synchronisers
  logic ck_s1, ck_s2, ck_s3;
  logic dqs_s1, dqs_s2, dqs_s3;
  link_cmd_t cmd_s1, cmd_s2;
  logic [7:0] dq_s1, dq_s2;
  logic mask_s1, mask_s2;
  logic term_s1, term_s2;

  always_ff @(posedge ref_clk)
  begin
    ck_s1 <= ck;
    ck_s2 <= ck_s1;
    ck_s3 <= ck_s2;
    dqs_s1 <= dqs;
    dqs_s2 <= dqs_s1;
    dqs_s3 <= dqs_s2;
    cmd_s1 <= cmd;
    cmd_s2 <= cmd_s1;
    dq_s1 <= dq;
    dq_s2 <= dq_s1;
    mask_s1 <= write_data_mask_n;
    mask_s2 <= mask_s1;
    term_s1 <= on_die_termination;
    term_s2 <= term_s1;
  end

  logic ck_rise;
  logic dqs_edge;
  assign ck_rise = ck_s2 && !ck_s3;
  assign dqs_edge = dqs_s2 ^ dqs_s3;

  // configuration and status registers
  logic [31:0] config_reg;
  logic cas_err, ccd_err;
  logic last_chop, last_rd_chop;
  logic [7:0] write_count;
  logic [31:0] next_config_reg;
  logic next_cas_err, next_ccd_err;

  logic [1:0] burst_mode;
  logic pre2_mode, tstr_en, inv_en;
  logic [4:0] write_cas_latency, additive_latency;
  logic [5:0] write_latency;
  logic [5:0] latency_eff;

  assign burst_mode = config_reg[cfg_burst_lsb +: 2];
  assign pre2_mode = config_reg[cfg_pre2_bit];
  assign tstr_en = config_reg[cfg_term_strobe_bit];
  assign inv_en = config_reg[cfg_inversion_bit];
  assign write_cas_latency = config_reg[cfg_cas_lat_lsb +: 5];
  assign additive_latency = config_reg[cfg_add_lat_lsb +: 5];
  assign write_latency = {1'b0, additive_latency} + {1'b0, write_cas_latency};
  assign latency_eff = (write_latency == 6'h00) ? 6'h01 : write_latency;

  logic apb_access, apb_write, apb_hit, busy;
  logic cas_err_set, ccd_err_set;
  logic [31:0] status_word;

  assign apb_access = psel && penable;
  assign apb_write = apb_access && pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[st_busy_bit] = busy;
    status_word[st_chop_bit] = last_chop;
    status_word[st_cas_err_bit] = cas_err;
    status_word[st_ccd_err_bit] = ccd_err;
    status_word[st_rd_chop_bit] = last_rd_chop;
    status_word[st_count_lsb +: 8] = write_count;
    apb_hit = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr == config_addr)
    begin
      prdata = config_reg;
    end
    else if (paddr == status_addr)
    begin
      prdata = status_word;
      prdata[st_busy_bit] = busy;
    end
    else if (paddr == latency_addr)
    begin
      prdata = {26'h0000000, write_latency};
    end
    else
    begin
      apb_hit = 1'b0;
    end
  end

  assign pslverr = apb_access && !apb_hit;

  always_comb
  begin
    next_config_reg = config_reg;
    if (apb_write && paddr == config_addr)
    begin
      next_config_reg = pwdata & config_mask;
    end
    next_cas_err = cas_err;
    next_ccd_err = ccd_err;
    if (apb_write && paddr == status_addr)
    begin
      if (pwdata[st_cas_err_bit])
      begin
        next_cas_err = 1'b0;
      end
      if (pwdata[st_ccd_err_bit])
      begin
        next_ccd_err = 1'b0;
      end
    end
    // a new violation wins over a clear in the same cycle
    if (cas_err_set)
    begin
      next_cas_err = 1'b1;
    end
    if (ccd_err_set)
    begin
      next_ccd_err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      config_reg <= config_reset;
      cas_err <= 1'b0;
      ccd_err <= 1'b0;
    end
    else
    begin
      config_reg <= next_config_reg;
      cas_err <= next_cas_err;
      ccd_err <= next_ccd_err;
    end
  end

  // write burst tracking on the command clock rising edges, beats on the data strobe edges
  burst_state_t state, next_state;
  logic [pend_depth-1:0] pend_go, pend_chop;
  logic [pend_depth-1:0] next_pend_go, next_pend_chop;
  logic [3:0] beats_left, next_beats_left;
  logic recov_wait, next_recov_wait;
  logic [5:0] since_write, next_since_write;
  logic next_last_chop, next_last_rd_chop;
  logic [7:0] next_write_count;
  logic next_beat_valid, next_recovery_ref;
  write_beat_t next_beat;
  logic write_now, read_now, pop_now, chop_now;
  logic [3:0] start_beats;

  assign write_now = ck_rise && cmd_s2.write;
  assign read_now = ck_rise && cmd_s2.read;
  assign pop_now = ck_rise && pend_go[0];
  assign chop_now = burst_is_chop(burst_mode, cmd_s2.chop_bit);
  assign start_beats = pend_chop[0] ? beats_of_four : beats_of_eight;
  assign busy = (state == st_burst) || (pend_go != '0);
  assign cas_err_set = write_now && pre2_mode
    && (write_cas_latency == lowest_write_cas_latency);
  assign ccd_err_set = write_now && pre2_mode && (since_write == forbidden_ccd_pre2);

  always_comb
  begin
    next_state = state;
    next_pend_go = pend_go;
    next_pend_chop = pend_chop;
    next_beats_left = beats_left;
    next_recov_wait = recov_wait;
    next_since_write = since_write;
    next_last_chop = last_chop;
    next_last_rd_chop = last_rd_chop;
    next_write_count = write_count;
    next_beat_valid = 1'b0;
    next_recovery_ref = 1'b0;
    next_beat = beat;
    if (ck_rise)
    begin
      next_pend_go = pend_go >> 1;
      next_pend_chop = pend_chop >> 1;
      if (since_write != 6'h3f)
      begin
        next_since_write = since_write + 6'h01;
      end
      if (recov_wait && !pend_go[0])
      begin
        next_recovery_ref = 1'b1;
        next_recov_wait = 1'b0;
      end
    end
    if (write_now)
    begin
      next_pend_go[latency_eff - 6'h01] = 1'b1;
      next_pend_chop[latency_eff - 6'h01] = chop_now;
      next_since_write = 6'h01;
      next_last_chop = chop_now;
      next_write_count = write_count + 8'h01;
    end
    if (read_now)
    begin
      next_last_rd_chop = chop_now;
    end
    if (pop_now)
    begin
      next_state = st_burst;
      next_beats_left = start_beats;
      next_recov_wait = 1'b0;
    end
    // read cycles never reach here, so the mask is ignored on reads
    if (dqs_edge && (state == st_burst || pop_now))
    begin
      next_beat_valid = 1'b1;
      next_beat.data = dq_s2;
      next_beat.masked = 1'b0;
      next_beat.inverted = 1'b0;
      if (inv_en)
      begin
        next_beat.inverted = !mask_s2;
        next_beat.data = mask_s2 ? dq_s2 : ~dq_s2;
      end
      else if (!tstr_en)
      begin
        next_beat.masked = !mask_s2;
      end
      next_beats_left = (pop_now ? start_beats : beats_left) - 4'h1;
      if (next_beats_left == 4'h0)
      begin
        next_state = st_idle;
        next_recov_wait = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state <= st_idle;
      pend_go <= '0;
      pend_chop <= '0;
      beats_left <= 4'h0;
      recov_wait <= 1'b0;
      since_write <= 6'h3f;
      last_chop <= 1'b0;
      last_rd_chop <= 1'b0;
      write_count <= 8'h00;
      beat_valid <= 1'b0;
      recovery_ref <= 1'b0;
      beat <= '0;
      on_die_termination_active <= 1'b0;
      termination_strobe_true_active <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pend_go <= next_pend_go;
      pend_chop <= next_pend_chop;
      beats_left <= next_beats_left;
      recov_wait <= next_recov_wait;
      since_write <= next_since_write;
      last_chop <= next_last_chop;
      last_rd_chop <= next_last_rd_chop;
      write_count <= next_write_count;
      beat_valid <= next_beat_valid;
      recovery_ref <= next_recovery_ref;
      beat <= next_beat;
      on_die_termination_active <= term_s2;
      termination_strobe_true_active <= tstr_en && !inv_en && (state == st_burst);
    end
  end

endmodule

`default_nettype wire

/* sdram_wr_pkg.sv */
package sdram_wr_pkg;

  // apb register byte addresses
  localparam logic [7:0] config_addr = 8'h00;
  localparam logic [7:0] status_addr = 8'h04;
  localparam logic [7:0] latency_addr = 8'h08;

  // config field positions
  localparam int cfg_burst_lsb = 0;
  localparam int cfg_pre2_bit = 2;
  localparam int cfg_term_strobe_bit = 3;
  localparam int cfg_inversion_bit = 4;
  localparam int cfg_cal_lsb = 5;
  localparam int cfg_cas_lat_lsb = 8;
  localparam int cfg_add_lat_lsb = 13;
  localparam logic [31:0] config_reset = 32'h0000_0900;
  localparam logic [31:0] config_mask = 32'h0003_ffff;

  // status field positions
  localparam int st_busy_bit = 0;
  localparam int st_chop_bit = 1;
  localparam int st_cas_err_bit = 2;
  localparam int st_ccd_err_bit = 3;
  localparam int st_rd_chop_bit = 4;
  localparam int st_count_lsb = 8;

  // mode register zero burst field codes
  localparam logic [1:0] burst_fixed_eight = 2'b00;
  localparam logic [1:0] burst_per_command = 2'b01;
  localparam logic [1:0] burst_fixed_chop = 2'b10;

  localparam logic [4:0] lowest_write_cas_latency = 5'h09;
  localparam logic [5:0] forbidden_ccd_pre2 = 6'h05;
  localparam logic [3:0] beats_of_eight = 4'h8;
  localparam logic [3:0] beats_of_four = 4'h4;
  localparam int pend_depth = 64;

  typedef enum logic {st_idle = 1'b0, st_burst = 1'b1} burst_state_t;

  typedef struct packed {
    logic write;
    logic read;
    logic chop_bit;
  } link_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic masked;
    logic inverted;
  } write_beat_t;

endpackage

/* sdram_write_burst_path_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sdram_write_burst_path_properties
  import sdram_wr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic on_die_termination,
  input wire sdram_wr_pkg::write_beat_t beat,
  input wire logic beat_valid,
  input wire logic recovery_ref,
  input wire logic on_die_termination_active,
  input wire logic termination_strobe_true_active
);
  import sdram_wr_pkg::*;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // beats seen since the last burst end
  always_comb
  begin
    next_cnt = recovery_ref ? {3'h0, beat_valid} : cnt + {3'h0, beat_valid};
  end
  always_ff @(posedge ref_clk)
  begin
    cnt <= srst ? 4'h0 : next_cnt;
  end
  property p_beat_pulse; beat_valid |=> !beat_valid; endproperty
  a_beat_pulse: assert property (p_beat_pulse)
    else $error("beat valid wider than one cycle");
  property p_beat_hold; !$stable(beat) |-> beat_valid; endproperty
  a_beat_hold: assert property (p_beat_hold)
    else $error("beat changed without a capture");
  property p_rec_pulse; recovery_ref |=> (!recovery_ref)[*4]; endproperty
  a_rec_pulse: assert property (p_rec_pulse)
    else $error("recovery reference repeated too soon");
  property p_cnt_cap; cnt <= 4'h8; endproperty
  a_cnt_cap: assert property (p_cnt_cap)
    else $error("more than eight beats in one burst");
  property p_burst_len; recovery_ref && cnt != 4'h0 |-> cnt == 4'h4 || cnt == 4'h8; endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst ended with a wrong beat count");
  property p_term_delay;
    !$past(srst) && !$past(srst, 2) && !$past(srst, 3) |->
      on_die_termination_active == $past(on_die_termination, 3);
  endproperty
  a_term_delay: assert property (p_term_delay)
    else $error("termination control not delayed by three cycles");
  property p_inv_excl; beat_valid && beat.inverted |-> !beat.masked; endproperty
  a_inv_excl: assert property (p_inv_excl)
    else $error("inverted beat also marked masked");
  property p_term_strobe;
    beat_valid && $past(termination_strobe_true_active) |-> !beat.masked && !beat.inverted;
  endproperty
  a_term_strobe: assert property (p_term_strobe)
    else $error("mask applied while pin is a termination strobe");
endmodule
`default_nettype wire

/* sdram_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model
  import sdram_wr_pkg::*;
(
  output logic ck,
  output sdram_wr_pkg::link_cmd_t cmd,
  output logic dqs,
  output logic [7:0] dq,
  output logic write_data_mask_n
);
  import sdram_wr_pkg::*;
  initial
  begin
    ck = 1'b0;
    cmd = '0;
    dqs = 1'b0;
    dq = 8'h00;
    write_data_mask_n = 1'b1;
  end
  // free running command clock, strobes toggle on both of its edges, the first on a fall
  always #100 ck = ~ck;
  task automatic burst(input logic rd, input logic cb, input int lat, input logic [7:0] d0,
    input logic [7:0] mk);
    int i;
    @(negedge ck);
    cmd <= '{write: !rd, read: rd, chop_bit: cb};
    @(negedge ck);
    cmd <= '0;
    repeat (lat - 1) @(negedge ck);
    dqs <= ~dqs;
    for (i = 0; i < 8; i++)
    begin
      #50;
      dq <= d0 + 8'(i);
      write_data_mask_n <= ~mk[i];
      #50;
      dqs <= ~dqs;
    end
    #50;
    dq <= ~dq;
    write_data_mask_n <= ~write_data_mask_n;
  endtask
  // bare write command; the next command may follow gap clocks later
  task automatic issue(input int gap);
    @(negedge ck);
    cmd <= '{write: 1'b1, read: 1'b0, chop_bit: 1'b1};
    @(negedge ck);
    cmd <= '0;
    repeat (gap - 2) @(negedge ck);
  endtask
endmodule
`default_nettype wire

/* sdram_write_burst_path_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sdram_write_burst_path_test;
  import sdram_wr_pkg::*;
  typedef struct {logic [1:0] mode; logic cb; logic tstr; logic inv; int n;} row_t;
  localparam logic [7:0] mk = 8'h5a;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ck;
  link_cmd_t cmd;
  logic on_die_termination = 1'b0;
  logic dqs;
  logic [7:0] dq;
  logic write_data_mask_n;
  write_beat_t beat;
  logic beat_valid;
  logic recovery_ref;
  logic on_die_termination_active;
  logic termination_strobe_true_active;
  int miscompares = 0;
  int checks = 0;
  int recs = 0;
  logic [31:0] rd;
  logic err;
  write_beat_t q[$];
  row_t rows[7] = '{'{2'b00, 1'b0, 1'b0, 1'b0, 8}, '{2'b01, 1'b1, 1'b0, 1'b0, 8},
    '{2'b01, 1'b0, 1'b0, 1'b0, 4}, '{2'b10, 1'b1, 1'b0, 1'b0, 4},
    '{2'b00, 1'b0, 1'b0, 1'b1, 8}, '{2'b00, 1'b0, 1'b1, 1'b0, 8},
    '{2'b11, 1'b0, 1'b0, 1'b0, 8}};
  sdram_write_burst_path uut (.*);
  sdram_ctrl_model ctl (.*);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (beat_valid === 1'b1)
      q.push_back(beat);
    if (recovery_ref === 1'b1)
      recs++;
  end
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50)
    begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic run(input row_t r, input int lat, input logic [7:0] d0);
    write_beat_t e;
    int i;
    q.delete();
    recs = 0;
    ctl.burst(1'b0, r.cb, lat, d0, mk);
    for (i = 0; i < 200 && recs == 0; i++)
      @(posedge ref_clk);
    if (recs == 0)
    begin
      miscompares++;
      close_out();
    end
    chk("beat count", r.n, q.size());
    for (i = 0; i < r.n && i < q.size(); i++)
    begin
      e.data = (r.inv && mk[i]) ? ~(d0 + 8'(i)) : d0 + 8'(i);
      e.masked = !r.inv && !r.tstr && mk[i];
      e.inverted = r.inv && mk[i];
      chk("beat", 32'(e), 32'(q[i]));
    end
    chk("recovery", 1, recs);
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    apb(1'b0, config_addr, 32'h0);
    chk("config reset", config_reset, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", 1, 32'(err));
    chk("unmapped data", 0, rd);
    $display("reset test done");
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, config_addr, 32'h900 | {27'h0, rows[i].inv, rows[i].tstr, 1'b0, rows[i].mode});
      run(rows[i], 9, 8'h30 + 8'(16 * i));
      $display("row %0d done", i);
    end
    on_die_termination <= 1'b1;
    apb(1'b1, config_addr, 32'h0000_4a00);
    apb(1'b0, latency_addr, 32'h0);
    chk("write latency", 12, rd);
    run(rows[0], 12, 8'hc0);
    on_die_termination <= 1'b0;
    q.delete();
    ctl.burst(1'b1, 1'b1, 12, 8'h11, 8'hff);
    repeat (40) @(posedge ref_clk);
    chk("read beats", 0, q.size());
    $display("latency and read test done");
    apb(1'b1, config_addr, 32'h0000_0904);
    run(rows[0], 9, 8'h70);
    apb(1'b0, status_addr, 32'h0);
    chk("cas latency error", 1, 32'(rd[st_cas_err_bit]));
    $display("preamble test done");
    apb(1'b1, config_addr, 32'h0000_0a04);
    ctl.issue(6);
    ctl.issue(6);
    apb(1'b0, status_addr, 32'h0);
    chk("spacing six", 0, 32'(rd[st_ccd_err_bit]));
    ctl.issue(5);
    ctl.issue(5);
    apb(1'b0, status_addr, 32'h0);
    chk("spacing five", 1, 32'(rd[st_ccd_err_bit]));
    apb(1'b1, status_addr, 32'h0000_0008);
    apb(1'b0, status_addr, 32'h0);
    chk("spacing clear", 0, 32'(rd[st_ccd_err_bit]));
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    apb(1'b0, status_addr, 32'h0);
    chk("status after reset", 0, rd);
    apb(1'b0, config_addr, 32'h0);
    chk("config after reset", config_reset, rd);
    run(rows[0], 9, 8'h50);
    $display("spacing and reset test done");
    close_out();
  end
endmodule
bind sdram_write_burst_path sdram_write_burst_path_properties chk_i (.*);
`default_nettype wire
